// file: sim/hsc_bank_properties.sv
// Register port checker for the pulse counter bank
`timescale 1ns/1ps
module hsc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ****
	// Checks
	// ****
	logic mapped;
	logic acc;
	assign mapped = paddr[1:0] == 2'b00 &&
		(paddr < 12'h020 || (paddr >= 12'h040 && paddr <= 12'h090));
	assign acc = psel && penable && !pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_answer_one_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("late answer");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("ready without access");
	a_idle_data: assert property (!pready |-> prdata == 32'h0)
		else $error("data outside answer");
	a_unmapped_err: assert property (acc && !mapped |=> pslverr)
		else $error("no error on unmapped");
	a_mapped_ok: assert property (acc && mapped |=> !pslverr)
		else $error("error on mapped");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_pins_upper: assert property (pready && !pwrite && paddr == 12'h01c
		|-> prdata[31:8] == 24'h0)
		else $error("pin word upper bits set");
	c_write: cover property (pready && pwrite);
	c_read: cover property (pready && !pwrite && prdata != 32'h0);
	c_error: cover property (pslverr);
endmodule : hsc_chk

bind hsc_bank hsc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr));

// file: sim/hsc_pulse_src.sv
// Encoder and pulse source model on the eight input pins
`timescale 1ns/1ps
module hsc_pulse_src (
	input wire logic pclk,
	output logic [7:0] pins
);
	// ****
	// Waveforms
	// ****
	initial pins = 8'h00;
	task automatic pulse(input int p, input int n, input int hi, input int lo);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			pins[p] <= 1'b1;
			repeat (hi) @(posedge pclk);
			pins[p] <= 1'b0;
			repeat (lo - 1) @(posedge pclk);
		end
	endtask : pulse
	task automatic level(input int p, input logic v);
		@(posedge pclk);
		pins[p] <= v;
		repeat (12) @(posedge pclk);
	endtask : level
	// Phase A on pin 0, B on pin 1; forward means A leads
	task automatic quad(input int n, input logic rev);
		logic [7:0] seq;
		seq = rev ? 8'hb4 : 8'h78;
		for (int i = 0; i < n; i++) begin
			for (int k = 3; k >= 0; k--) begin
				@(posedge pclk);
				pins[1:0] <= seq[k*2 +: 2];
				repeat (11) @(posedge pclk);
			end
		end
	endtask : quad
endmodule : hsc_pulse_src

// file: sim/tb_high_speed_pulse_counter_bank.sv
// Self-checking bench for the pulse counter bank
`timescale 1ns/1ps
module tb_high_speed_pulse_counter_bank;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] input_pins;
	int miscompares = 0;
	int samples_checked = 0;

	initial forever #10 pclk = ~pclk;

	hsc_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.input_pins(input_pins));
	hsc_pulse_src src (.pclk(pclk), .pins(input_pins));

	// ****
	// Helpers
	// ****
	task results;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	task chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			$display("unexpected at %0t: got %h want %h", $time, g, x);
			miscompares++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			$display("unexpected at %0t: no answer", $time);
			miscompares++;
			results();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask : rc
	function automatic logic [11:0] va(input int i);
		return hsc_pkg::OFS_VALUE + 12'(4 * i);
	endfunction : va

	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		rc(hsc_pkg::OFS_SWMODE, {11'h0, hsc_pkg::SW_BASE});
		rc(va(20), 32'h0);
		apb(1'b0, 12'h020, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		$display("reset test done");
	endtask : t_reset
	task automatic t_single;
		wr(hsc_pkg::OFS_ENABLE, 32'h1);
		src.pulse(0, 3, 12, 12);
		rc(va(0), 32'h3);
		wr(hsc_pkg::OFS_DIRCTL, 32'h1);
		src.pulse(0, 5, 12, 12);
		rc(va(0), 32'hfffffffe);
		rc(hsc_pkg::OFS_DIRFLAG, 32'h1);
		wr(hsc_pkg::OFS_DIRCTL, 32'h0);
		$display("single test done");
	endtask : t_single
	task automatic t_dual;
		wr(hsc_pkg::OFS_ENABLE, 32'h800);
		src.pulse(0, 2, 12, 12);
		src.pulse(1, 1, 12, 12);
		rc(va(11), 32'h1);
		rc(hsc_pkg::OFS_DIRFLAG, 32'h800);
		$display("dual test done");
	endtask : t_dual
	task automatic t_quad;
		wr(hsc_pkg::OFS_ENABLE, 32'h10000);
		src.quad(2, 1'b0);
		rc(va(16), 32'h2);
		wr(hsc_pkg::OFS_CTRL, 32'h21);
		src.quad(2, 1'b0);
		rc(va(16), 32'ha);
		src.quad(1, 1'b1);
		rc(va(16), 32'h6);
		rc(hsc_pkg::OFS_DIRFLAG, 32'h10800);
		wr(hsc_pkg::OFS_CTRL, 32'h0);
		$display("quadrature test done");
	endtask : t_quad
	task automatic t_rst_start;
		wr(hsc_pkg::OFS_ENABLE, 32'h40);
		src.pulse(0, 2, 12, 12);
		rc(va(6), 32'h2);
		src.pulse(1, 1, 12, 12);
		rc(va(6), 32'h0);
		wr(hsc_pkg::OFS_CTRL, 32'h3);
		src.level(1, 1'b1);
		src.pulse(0, 2, 12, 12);
		rc(va(6), 32'h2);
		src.level(1, 1'b0);
		rc(va(6), 32'h0);
		wr(hsc_pkg::OFS_CTRL, 32'h0);
		wr(hsc_pkg::OFS_ENABLE, 32'h200);
		src.pulse(0, 2, 12, 12);
		rc(va(9), 32'h0);
		src.pulse(6, 1, 12, 12);
		src.pulse(0, 3, 12, 12);
		rc(va(9), 32'h3);
		$display("reset and start test done");
	endtask : t_rst_start
	task automatic t_modes;
		wr(hsc_pkg::OFS_CTRL, 32'h11);
		rc(hsc_pkg::OFS_SWMODE,
			{11'h0, (hsc_pkg::SW_BASE & ~21'h002000) | 21'h040000});
		wr(hsc_pkg::OFS_CTRL, 32'h0d);
		rc(hsc_pkg::OFS_SWMODE, {11'h0, hsc_pkg::SW_BASE & ~21'h000600});
		wr(hsc_pkg::OFS_CTRL, 32'h0);
		wr(hsc_pkg::OFS_FORCE_SW, 32'h1);
		rc(hsc_pkg::OFS_SWMODE, {11'h0, hsc_pkg::SW_BASE | 21'h1});
		$display("mode test done");
	endtask : t_modes
	task automatic t_overrun;
		wr(hsc_pkg::OFS_ENABLE, 32'h1);
		src.pulse(0, 4, 3, 3);
		repeat (12) @(posedge pclk);
		rc(hsc_pkg::OFS_OVERRUN, 32'h1);
		rc(va(0), 32'h0);
		wr(hsc_pkg::OFS_OVERRUN, 32'h1);
		rc(hsc_pkg::OFS_OVERRUN, 32'h0);
		$display("overrun test done");
	endtask : t_overrun

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_single();
		t_dual();
		t_quad();
		t_rst_start();
		t_modes();
		t_overrun();
		results();
	end
endmodule : tb_high_speed_pulse_counter_bank

// file: src/hsc_bank.sv
// Bank of 21 pulse counters on eight input pins, with an APB slave
`timescale 1ns/1ps

module hsc_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] input_pins
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [hsc_pkg::NPIN-1:0] s1;
		logic [hsc_pkg::NPIN-1:0] s2;
		logic [hsc_pkg::NPIN-1:0] s3;
		logic [hsc_pkg::NPIN-1:0] pins;
		logic [hsc_pkg::CTRL_W-1:0] ctrl;
		logic [hsc_pkg::NSGL-1:0] dirctl;
		logic [hsc_pkg::NCNT-1:0] enable;
		logic [hsc_pkg::NCNT-1:0] force_sw;
		logic [hsc_pkg::NCNT-1:0] overrun;
		logic [hsc_pkg::GAP_W-1:0] gap;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} hsc_bank_t;

	hsc_bank_t cur;
	hsc_bank_t next_cur;

	logic [hsc_pkg::NCNT-1:0][31:0] value;
	logic [hsc_pkg::NCNT-1:0] dir;
	logic [hsc_pkg::NCNT-1:0] req;
	logic [hsc_pkg::NCNT-1:0] drop;
	logic [hsc_pkg::NCNT-1:0] grant;
	logic [hsc_pkg::NCNT-1:0] sw_mode;
	logic [hsc_pkg::NCNT-1:0] load;
	logic [hsc_pkg::NCNT:0] chain;
	logic func;
	logic gap_ok;
	logic wr;
	logic rd_go;
	logic [31:0] rdata;
	logic rerr;
	// One-hot register selects
	logic sel_ctrl;
	logic sel_dirctl;
	logic sel_enable;
	logic sel_force_sw;
	logic sel_dirflag;
	logic sel_swmode;
	logic sel_overrun;
	logic sel_pins;
	logic sel_value;
	logic [4:0] val_idx;

	// ****************************************
	// Bus qualifiers
	// ****************************************
	assign func = cur.ctrl[hsc_pkg::BIT_FUNC];
	assign gap_ok = (cur.gap == '0);
	// Writes land on the edge the master sees pready
	assign wr = psel & penable & pwrite & cur.pready;
	assign rd_go = psel & penable & ~cur.pready;
	assign chain[0] = 1'b0;

	// ****************************************
	// Counter cells
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < hsc_pkg::NCNT; gi++) begin : g_cnt
			logic remap;
			logic x4;
			logic has_r;
			logic has_s;
			logic sw;
			logic [2:0] pa;
			logic dctl;

			always_comb begin
				remap = func & (
					(hsc_pkg::REMAP_A[gi] & cur.ctrl[hsc_pkg::BIT_REMAP_A]) |
					(hsc_pkg::REMAP_B[gi] & cur.ctrl[hsc_pkg::BIT_REMAP_B]) |
					(hsc_pkg::REMAP_C[gi] & cur.ctrl[hsc_pkg::BIT_REMAP_C]));
				x4 = func & (
					(hsc_pkg::X4_A[gi] & cur.ctrl[hsc_pkg::BIT_X4_A]) |
					(hsc_pkg::X4_B[gi] & cur.ctrl[hsc_pkg::BIT_X4_B]));
				// Remapped variants lose reset and start
				has_r = hsc_pkg::HAS_R[gi] & ~remap;
				has_s = hsc_pkg::HAS_S[gi] & ~remap;
				pa = remap ? hsc_pkg::PIN_OP[gi] : hsc_pkg::PIN_A[gi];
				if (gi == hsc_pkg::Q_HW_B) begin
					// Inverted reset logic also drops it to software
					sw = remap | cur.force_sw[gi] |
						(func & cur.ctrl[hsc_pkg::BIT_RSTPOL]);
				end else if (remap) begin
					sw = 1'b0;
				end else begin
					sw = hsc_pkg::SW_BASE[gi] | cur.force_sw[gi];
				end
				if (gi < hsc_pkg::NSGL) begin
					dctl = cur.dirctl[gi];
				end else begin
					dctl = 1'b0;
				end
			end

			assign sw_mode[gi] = sw;
			assign load[gi] = wr &
				(paddr == hsc_pkg::OFS_VALUE + 12'(gi * 4));
			// Lowest index wins the shared software slot
			assign chain[gi+1] = chain[gi] | req[gi];
			assign grant[gi] = req[gi] & ~chain[gi] & gap_ok;

			hsc_cell u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.kind(hsc_pkg::KIND[gi]),
				.x4(x4),
				.has_r(has_r),
				.has_s(has_s),
				.rst_pol(func & cur.ctrl[hsc_pkg::BIT_RSTPOL]),
				.sw_mode(sw),
				.enable(cur.enable[gi]),
				.dir_ctl(dctl),
				.in_a(cur.pins[pa]),
				.in_b(cur.pins[hsc_pkg::PIN_B[gi]]),
				.in_r(cur.pins[hsc_pkg::PIN_R[gi]]),
				.in_s(cur.pins[hsc_pkg::PIN_S[gi]]),
				.load(load[gi]),
				.load_val(pwdata),
				.grant(grant[gi]),
				.value(value[gi]),
				.dir(dir[gi]),
				.req(req[gi]),
				.drop(drop[gi])
			);
		end
	endgenerate

	// ****************************************
	// Address decode
	// ****************************************
	always_comb begin
		sel_ctrl = 1'b0;
		sel_dirctl = 1'b0;
		sel_enable = 1'b0;
		sel_force_sw = 1'b0;
		sel_dirflag = 1'b0;
		sel_swmode = 1'b0;
		sel_overrun = 1'b0;
		sel_pins = 1'b0;
		sel_value = 1'b0;
		if (paddr == hsc_pkg::OFS_CTRL) begin
			sel_ctrl = 1'b1;
		end else if (paddr == hsc_pkg::OFS_DIRCTL) begin
			sel_dirctl = 1'b1;
		end else if (paddr == hsc_pkg::OFS_ENABLE) begin
			sel_enable = 1'b1;
		end else if (paddr == hsc_pkg::OFS_FORCE_SW) begin
			sel_force_sw = 1'b1;
		end else if (paddr == hsc_pkg::OFS_DIRFLAG) begin
			sel_dirflag = 1'b1;
		end else if (paddr == hsc_pkg::OFS_SWMODE) begin
			sel_swmode = 1'b1;
		end else if (paddr == hsc_pkg::OFS_OVERRUN) begin
			sel_overrun = 1'b1;
		end else if (paddr == hsc_pkg::OFS_PINS) begin
			sel_pins = 1'b1;
		end else if (paddr >= hsc_pkg::OFS_VALUE &&
			paddr < hsc_pkg::OFS_VALUE + 12'(hsc_pkg::NCNT * 4) &&
			paddr[1:0] == 2'h0) begin
			sel_value = 1'b1;
		end
	end

	// Counter index of a value word
	assign val_idx = 5'(paddr[11:2] - hsc_pkg::OFS_VALUE[11:2]);

	// ****************************************
	// Read decode
	// ****************************************
	always_comb begin
		rdata = 32'h00000000;
		rerr = 1'b0;
		if (sel_ctrl) begin
			rdata = {25'h0000000, cur.ctrl};
		end else if (sel_dirctl) begin
			rdata = {21'h000000, cur.dirctl};
		end else if (sel_enable) begin
			rdata = {11'h000, cur.enable};
		end else if (sel_force_sw) begin
			rdata = {11'h000, cur.force_sw};
		end else if (sel_dirflag) begin
			rdata = {11'h000, dir};
		end else if (sel_swmode) begin
			rdata = {11'h000, sw_mode};
		end else if (sel_overrun) begin
			rdata = {11'h000, cur.overrun};
		end else if (sel_pins) begin
			rdata = {24'h000000, cur.pins};
		end else if (sel_value) begin
			rdata = value[val_idx];
		end else begin
			rerr = 1'b1;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_cur = cur;
		// Three-stage input sync, accept when last two agree
		next_cur.s1 = input_pins;
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
		for (int i = 0; i < hsc_pkg::NPIN; i++) begin
			if (cur.s2[i] == cur.s3[i]) begin
				next_cur.pins[i] = cur.s3[i];
			end
		end
		// APB answer one cycle into the access phase
		next_cur.pready = rd_go;
		if (rd_go) begin
			next_cur.prdata = pwrite ? 32'h00000000 : rdata;
			next_cur.pslverr = rerr;
		end else begin
			next_cur.prdata = 32'h00000000;
			next_cur.pslverr = 1'b0;
		end
		if (wr) begin
			if (sel_ctrl) begin
				next_cur.ctrl = pwdata[hsc_pkg::CTRL_W-1:0];
			end else if (sel_dirctl) begin
				next_cur.dirctl = pwdata[hsc_pkg::NSGL-1:0];
			end else if (sel_enable) begin
				next_cur.enable = pwdata[hsc_pkg::NCNT-1:0];
			end else if (sel_force_sw) begin
				next_cur.force_sw = pwdata[hsc_pkg::NCNT-1:0];
			end else if (sel_overrun) begin
				next_cur.overrun = cur.overrun & ~pwdata[hsc_pkg::NCNT-1:0];
			end
		end
		// Lost software pulses; set wins over clear
		next_cur.overrun = next_cur.overrun | drop;
		// Bank-wide pacing of software counting
		if (|grant) begin
			next_cur.gap = hsc_pkg::GAP_W'(hsc_pkg::SW_TOTAL_CYC);
		end else if (!gap_ok) begin
			next_cur.gap = cur.gap - 8'h1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur.s1 <= '0;
			cur.s2 <= '0;
			cur.s3 <= '0;
			cur.pins <= '0;
			cur.ctrl <= hsc_pkg::CTRL_RST;
			cur.dirctl <= hsc_pkg::DIRCTL_RST;
			cur.enable <= hsc_pkg::ENABLE_RST;
			cur.force_sw <= hsc_pkg::FORCE_SW_RST;
			cur.overrun <= hsc_pkg::OVERRUN_RST;
			cur.gap <= '0;
			cur.prdata <= 32'h00000000;
			cur.pready <= 1'b0;
			cur.pslverr <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;

endmodule : hsc_bank

// file: src/hsc_cell.sv
// One 32-bit up/down pulse counter with reset, start and pacing
`timescale 1ns/1ps
module hsc_cell (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] kind,
	input wire logic x4,
	input wire logic has_r,
	input wire logic has_s,
	input wire logic rst_pol,
	input wire logic sw_mode,
	input wire logic enable,
	input wire logic dir_ctl,
	input wire logic in_a,
	input wire logic in_b,
	input wire logic in_r,
	input wire logic in_s,
	input wire logic load,
	input wire logic [31:0] load_val,
	input wire logic grant,
	output logic [31:0] value,
	output logic dir,
	output logic req,
	output logic drop
);

	typedef struct packed {
		logic [hsc_pkg::VW-1:0] value;
		logic dir;
		logic pa;
		logic pb;
		logic pr;
		logic ps;
		logic run;
		logic [hsc_pkg::GAP_W-1:0] gap;
	} hsc_cell_t;

	hsc_cell_t cur;
	hsc_cell_t next_cur;
	logic rise_a;
	logic rise_b;
	logic step;
	logic down;
	logic want;
	logic cnt;
	logic rst_ev;

	always_comb begin
		next_cur = cur;
		rise_a = in_a & ~cur.pa;
		rise_b = in_b & ~cur.pb;
		step = 1'b0;
		down = 1'b0;
		case (kind)
			hsc_pkg::HSC_SINGLE: begin
				step = rise_a;
				down = dir_ctl;
			end
			hsc_pkg::HSC_DUAL: begin
				step = rise_a ^ rise_b;
				down = rise_b;
			end
			default: begin
				if (x4) begin
					step = (in_a ^ cur.pa) ^ (in_b ^ cur.pb);
					down = cur.pa ^ in_b;
				end else begin
					step = rise_a;
					down = in_b;
				end
			end
		endcase
		// Start input gates counting
		want = enable & (cur.run | ~has_s) & step;
		req = want & sw_mode & (cur.gap == '0);
		drop = want & sw_mode & ~grant;
		cnt = want & (~sw_mode | grant);
		rst_ev = has_r & (rst_pol ? (cur.pr & ~in_r) : (in_r & ~cur.pr));
		if (has_s & in_s & ~cur.ps) begin
			next_cur.run = 1'b1;
		end
		if (kind == hsc_pkg::HSC_SINGLE) begin
			next_cur.dir = dir_ctl;
		end else if (cnt) begin
			next_cur.dir = down;
		end
		if (load) begin
			next_cur.value = load_val;
		end else if (rst_ev) begin
			next_cur.value = hsc_pkg::VALUE_RST;
			next_cur.run = 1'b0;
		end else if (cnt) begin
			next_cur.value = down ? cur.value - 32'h1 : cur.value + 32'h1;
		end
		if (cnt & sw_mode) begin
			next_cur.gap = hsc_pkg::GAP_W'(hsc_pkg::SW_GAP_CYC);
		end else if (cur.gap != '0) begin
			next_cur.gap = cur.gap - 8'h1;
		end
		next_cur.pa = in_a;
		next_cur.pb = in_b;
		next_cur.pr = in_r;
		next_cur.ps = in_s;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign value = cur.value;
	assign dir = cur.dir;

endmodule : hsc_cell

// file: src/hsc_pkg.sv
// Shared constants, register map and counter wiring tables of the bank
package hsc_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NCNT = 21;
	localparam int NPIN = 8;
	localparam int NSGL = 11;
	localparam int VW = 32;
	localparam int AW = 12;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [AW-1:0] OFS_CTRL = 12'h000;
	localparam logic [AW-1:0] OFS_DIRCTL = 12'h004;
	localparam logic [AW-1:0] OFS_ENABLE = 12'h008;
	localparam logic [AW-1:0] OFS_FORCE_SW = 12'h00c;
	localparam logic [AW-1:0] OFS_DIRFLAG = 12'h010;
	localparam logic [AW-1:0] OFS_SWMODE = 12'h014;
	localparam logic [AW-1:0] OFS_OVERRUN = 12'h018;
	localparam logic [AW-1:0] OFS_PINS = 12'h01c;
	localparam logic [AW-1:0] OFS_VALUE = 12'h040;

	// Control register fields
	localparam int CTRL_W = 7;
	localparam int BIT_FUNC = 0;
	localparam int BIT_RSTPOL = 1;
	localparam int BIT_REMAP_A = 2;
	localparam int BIT_REMAP_B = 3;
	localparam int BIT_REMAP_C = 4;
	localparam int BIT_X4_A = 5;
	localparam int BIT_X4_B = 6;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [NSGL-1:0] DIRCTL_RST = 11'h000;
	localparam logic [NCNT-1:0] ENABLE_RST = 21'h000000;
	localparam logic [NCNT-1:0] FORCE_SW_RST = 21'h000000;
	localparam logic [NCNT-1:0] OVERRUN_RST = 21'h000000;
	localparam logic [VW-1:0] VALUE_RST = 32'h00000000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 20;
	localparam int SW_GAP_NS = 200;
	localparam int SW_TOTAL_GAP_NS = 40;
	localparam int SW_GAP_CYC = (SW_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int SW_TOTAL_CYC = (SW_TOTAL_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_W = 8;

	// ****************************************
	// Counter kinds and wiring
	// ****************************************
	typedef enum logic [2:0] {
		HSC_SINGLE = 3'b001,
		HSC_DUAL = 3'b010,
		HSC_QUAD = 3'b100
	} hsc_kind_t;

	localparam int Q_HW_B = 18;
	localparam logic [NCNT-1:0] SW_BASE = 21'h1af7c0;
	localparam logic [NCNT-1:0] HAS_R = 21'h1ef7c0;
	localparam logic [NCNT-1:0] HAS_S = 21'h18c600;
	localparam logic [NCNT-1:0] REMAP_A = 21'h000200;
	localparam logic [NCNT-1:0] REMAP_B = 21'h000400;
	localparam logic [NCNT-1:0] REMAP_C = 21'h042000;
	localparam logic [NCNT-1:0] X4_A = 21'h0b0000;
	localparam logic [NCNT-1:0] X4_B = 21'h140000;
	localparam logic [NCNT-1:0][2:0] PIN_A = {
		3'h3, 3'h0, 3'h3, 3'h0, 3'h0, 3'h3, 3'h0, 3'h3, 3'h0, 3'h0,
		3'h2, 3'h0, 3'h4, 3'h2, 3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1,
		3'h0};
	localparam logic [NCNT-1:0][2:0] PIN_OP = {
		3'h3, 3'h0, 3'h3, 3'h0, 3'h0, 3'h3, 3'h0, 3'h3, 3'h0, 3'h0,
		3'h7, 3'h6, 3'h4, 3'h2, 3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1,
		3'h0};
	localparam logic [NCNT-1:0][2:0] PIN_B = {
		3'h4, 3'h1, 3'h4, 3'h1, 3'h1, 3'h4, 3'h1, 3'h4, 3'h1, 3'h1,
		3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0};
	localparam logic [NCNT-1:0][2:0] PIN_R = {
		3'h5, 3'h2, 3'h5, 3'h2, 3'h0, 3'h5, 3'h2, 3'h5, 3'h2, 3'h0,
		3'h3, 3'h1, 3'h5, 3'h3, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0};
	localparam logic [NCNT-1:0][2:0] PIN_S = {
		3'h7, 3'h6, 3'h0, 3'h0, 3'h0, 3'h7, 3'h6, 3'h0, 3'h0, 3'h0,
		3'h7, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
		3'h0};
	localparam logic [NCNT-1:0][2:0] KIND = {
		3'b100, 3'b100, 3'b100, 3'b100, 3'b100,
		3'b010, 3'b010, 3'b010, 3'b010, 3'b010,
		3'b001, 3'b001, 3'b001, 3'b001, 3'b001, 3'b001, 3'b001,
		3'b001, 3'b001, 3'b001, 3'b001};

endpackage : hsc_pkg
